// [verilog/rxd_pkg.sv]
// Constants and descriptor layout for the receive descriptor handler.
// Assumes 16-bit shared memory words, word addressed, 24-bit byte address space.
// Overview of operation
// - Word 0 bit 15 set means controller owns.
// - Controller clears ownership only for valid units.
// - Host sets ownership after emptying the buffer.
// - Released descriptors stay untouched until returned.
// - Controller ignores the host versus processor bit.
// - Controller marks first buffer of a unit.
// - Controller marks last buffer; both means single.
// - International mode keeps bits 11 to 8 zero.
// - Japanese mode reports priority bits 11 and 10.
// - Upper address bits 7 to 0 stay unchanged.
// - Word 1 low address, word aligned, unchanged.
// - Word 2 buffer length, two's complement, unchanged.
// - Host programs an even buffer length.
// - Word 3 holds unit length on last buffer; code writes its two's complement into word 3 of every buffer.
// - Non-last buffers are full, length is count.
// - Each ring entry is four 16-bit words.
// - Ring length code 0..7 gives 1..128 entries.
package rxd_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int DESC_WORDS = 4;
    localparam int CODE_W = 3;
    localparam int MAX_CHAIN = 8;
    localparam int OWN_BIT = 15;
    localparam int HOSTIOP_BIT = 14;
    localparam int FIRST_BIT = 13;
    localparam int LAST_BIT = 12;
    localparam int PRIO_HI = 11;
    localparam int PRIO_LO = 10;
    localparam int RSV_HI = 11;
    localparam int RSV_LO = 8;
    localparam int UADDR_HI = 7;
    localparam logic [1:0] W0_OFS = 2'h0;
    localparam logic [1:0] W1_OFS = 2'h1;
    localparam logic [1:0] W2_OFS = 2'h2;
    localparam logic [1:0] W3_OFS = 2'h3;
    localparam logic [15:0] FLAG_CLR_MASK = 16'h40ff;
    localparam logic [6:0] ONE_ENTRY = 7'h01;
endpackage : rxd_pkg

// [verilog/rxd_mem_if.sv]
// Shared-memory port between the controller (master) and the host memory model.
// Assumes single-cycle memory: read data in the cycle after a read strobe.
`timescale 1ns/1ps
interface rxd_mem_if;
    import rxd_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] rdata;
    modport ctrl (output addr, output wdata, output wr, output rd, input rdata);
    modport host (input addr, input wdata, input wr, input rd, output rdata);
endinterface : rxd_mem_if

// [verilog/rxd_ring_ptr.sv]
// Ring index counter with power-of-two wrap.
// Assumes code is stable while the ring is running.
`timescale 1ns/1ps
module rxd_ring_ptr
    import rxd_pkg::*;
#(
    parameter int IDX_W = 7
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [CODE_W-1:0] ringCode, // Ring length code
    input wire logic restart, // Back to base entry
    input wire logic advance, // Step to next entry
    output logic [IDX_W-1:0] idx // Current entry index
);
    logic [IDX_W-1:0] idx_r;
    logic [IDX_W-1:0] idx_nxt;
    logic [IDX_W-1:0] lastIdx;

    assign lastIdx = IDX_W'((ONE_ENTRY << ringCode) - 7'h01);
    assign idx = idx_r;

    always_comb begin
        idx_nxt = idx_r;
        if (restart) begin
            idx_nxt = '0;
        end else if (advance) begin
            idx_nxt = (idx_r >= lastIdx) ? '0 : idx_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idx_r <= '0;
        end else begin
            idx_r <= idx_nxt;
        end
    end
endmodule : rxd_ring_ptr

// [verilog/rxd_ctrl_end.sv]
// Controller end: walks the receive ring and stores signal units into buffers.
// Assumes memory answers a read one cycle later and never stalls.
`timescale 1ns/1ps
module rxd_ctrl_end
    import rxd_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    rxd_mem_if.ctrl mem, // Shared memory port
    input wire logic [ADDR_W-1:0] ringBase, // Ring base word address
    input wire logic [CODE_W-1:0] ringCode, // Ring length code
    input wire logic japaneseModeEnable, // Japanese priority reporting
    input wire logic start, // Restart at base entry
    input wire logic suValid, // Byte pair valid
    input wire logic [15:0] suData, // Two bytes, first in low
    input wire logic suOdd, // Last pair holds one byte
    input wire logic suEnd, // Beside last pair
    input wire logic suGood, // Unit passed checks, with suEnd
    input wire logic [1:0] suPrio, // Priority bits of unit
    output logic suReady, // Pair accepted this cycle
    output logic unitDone, // Pulse: unit handed back
    output logic unitDropped, // Pulse: unit discarded
    output logic ringStall // Waiting on host-owned entry
);
    typedef enum {ST_IDLE, ST_RD0, ST_RD1, ST_RD2, ST_FILL, ST_W3, ST_W0, ST_DROP}
        rxd_state_e;
    rxd_state_e st_r, st_nxt;
    logic [15:0] w0_r, w0_nxt, w2_r, w2_nxt;
    logic [ADDR_W-1:0] bufPtr_r, bufPtr_nxt;
    logic [15:0] bufLeft_r, bufLeft_nxt, msgLen_r, msgLen_nxt;
    logic [2:0] nChain_r, nChain_nxt, rel_r, rel_nxt;
    logic [6:0] chainIdx_r [MAX_CHAIN];
    logic [6:0] chainIdx_nxt [MAX_CHAIN];
    logic [15:0] chainW0_r [MAX_CHAIN];
    logic [15:0] chainW0_nxt [MAX_CHAIN];
    logic good_r, good_nxt, endSeen_r, endSeen_nxt;
    logic [1:0] prio_r, prio_nxt;
    logic [6:0] idx, relIdx;
    logic advance;
    logic [ADDR_W-1:0] entryAddr, relAddr;
    logic [15:0] relW0;

    rxd_ring_ptr #(.IDX_W(7)) u_ptr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ringCode(ringCode),
        .restart(start),
        .advance(advance),
        .idx(idx)
    );

    assign entryAddr = ringBase + ADDR_W'({idx, 2'b00});
    assign relIdx = chainIdx_r[rel_r];
    assign relAddr = ringBase + ADDR_W'({relIdx, 2'b00});

    always_comb begin
        relW0 = chainW0_r[rel_r] & FLAG_CLR_MASK; // keep host bits
        relW0[OWN_BIT] = 1'b0;
        relW0[FIRST_BIT] = (rel_r == 3'h0);
        relW0[LAST_BIT] = (rel_r == nChain_r - 3'h1);
        if (japaneseModeEnable) begin
            relW0[PRIO_HI:PRIO_LO] = prio_r;
        end else begin
            relW0[RSV_HI:RSV_LO] = 4'h0;
        end
    end

    always_comb begin
        st_nxt = st_r;
        w0_nxt = w0_r;
        w2_nxt = w2_r;
        bufPtr_nxt = bufPtr_r;
        bufLeft_nxt = bufLeft_r;
        msgLen_nxt = msgLen_r;
        nChain_nxt = nChain_r;
        rel_nxt = rel_r;
        chainIdx_nxt = chainIdx_r;
        chainW0_nxt = chainW0_r;
        good_nxt = good_r;
        endSeen_nxt = endSeen_r;
        prio_nxt = prio_r;
        advance = 1'b0;
        suReady = 1'b0;
        unitDone = 1'b0;
        unitDropped = 1'b0;
        ringStall = 1'b0;
        mem.addr = entryAddr;
        mem.wdata = 16'h0000;
        mem.wr = 1'b0;
        mem.rd = 1'b0;
        if (start) begin
            st_nxt = ST_IDLE;
            nChain_nxt = 3'h0;
            msgLen_nxt = 16'h0000;
            endSeen_nxt = 1'b0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    mem.rd = 1'b1;
                    mem.addr = entryAddr + ADDR_W'(W0_OFS);
                    st_nxt = ST_RD0;
                end
                ST_RD0: begin
                    w0_nxt = mem.rdata;
                    mem.rd = 1'b1;
                    mem.addr = entryAddr + ADDR_W'(W1_OFS);
                    st_nxt = mem.rdata[OWN_BIT] ? ST_RD1 : ST_IDLE;
                    ringStall = !mem.rdata[OWN_BIT];
                end
                ST_RD1: begin
                    bufPtr_nxt = {w0_r[UADDR_HI:0], mem.rdata[15:1], 1'b0};
                    mem.rd = 1'b1;
                    mem.addr = entryAddr + ADDR_W'(W2_OFS);
                    st_nxt = ST_RD2;
                end
                ST_RD2: begin
                    w2_nxt = mem.rdata;
                    bufLeft_nxt = 16'h0000 - {mem.rdata[15:1], 1'b0};
                    chainIdx_nxt[nChain_r] = idx;
                    chainW0_nxt[nChain_r] = w0_r;
                    nChain_nxt = nChain_r + 3'h1;
                    st_nxt = ST_FILL;
                end
                ST_FILL: begin
                    suReady = (bufLeft_r != 16'h0000) && !endSeen_r;
                    if (endSeen_r) begin
                        rel_nxt = 3'h0;
                        st_nxt = good_r ? ST_W3 : ST_DROP;
                    end else if (bufLeft_r == 16'h0000) begin
                        if (nChain_r == 3'(MAX_CHAIN - 1)) begin
                            good_nxt = 1'b0;
                            endSeen_nxt = 1'b1;
                        end else begin
                            advance = 1'b1; // full buffer, chain on
                            st_nxt = ST_IDLE;
                        end
                    end else if (suValid) begin
                        mem.wr = 1'b1;
                        mem.addr = bufPtr_r >> 1;
                        mem.wdata = suData;
                        bufPtr_nxt = bufPtr_r + ADDR_W'(2);
                        bufLeft_nxt = bufLeft_r - 16'h0002;
                        msgLen_nxt = msgLen_r + (suOdd && suEnd ? 16'h0001 : 16'h0002);
                        if (suEnd) begin
                            endSeen_nxt = 1'b1;
                            good_nxt = suGood;
                            prio_nxt = suPrio;
                        end
                    end
                end
                ST_W3: begin
                    mem.wr = 1'b1;
                    mem.addr = relAddr + ADDR_W'(W3_OFS);
                    mem.wdata = 16'h0000 - msgLen_r;
                    st_nxt = ST_W0;
                end
                ST_W0: begin
                    mem.wr = 1'b1;
                    mem.addr = relAddr + ADDR_W'(W0_OFS);
                    mem.wdata = relW0; // ownership word written last
                    if (rel_r == nChain_r - 3'h1) begin
                        unitDone = 1'b1;
                        advance = 1'b1;
                        nChain_nxt = 3'h0;
                        msgLen_nxt = 16'h0000;
                        endSeen_nxt = 1'b0;
                        st_nxt = ST_IDLE;
                    end else begin
                        rel_nxt = rel_r + 3'h1;
                        st_nxt = ST_W3;
                    end
                end
                ST_DROP: begin
                    unitDropped = 1'b1;
                    advance = (nChain_r != 3'h0); // skip past the chain
                    for (int i = 0; i < MAX_CHAIN; i++) begin
                        chainIdx_nxt[i] = 7'h00;
                    end
                    nChain_nxt = 3'h0;
                    msgLen_nxt = 16'h0000;
                    endSeen_nxt = 1'b0;
                    st_nxt = ST_IDLE;
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            w0_r <= 16'h0000;
            w2_r <= 16'h0000;
            bufPtr_r <= '0;
            bufLeft_r <= 16'h0000;
            msgLen_r <= 16'h0000;
            nChain_r <= 3'h0;
            rel_r <= 3'h0;
            good_r <= 1'b0;
            endSeen_r <= 1'b0;
            prio_r <= 2'h0;
            for (int i = 0; i < MAX_CHAIN; i++) begin
                chainIdx_r[i] <= 7'h00;
                chainW0_r[i] <= 16'h0000;
            end
        end else begin
            st_r <= st_nxt;
            w0_r <= w0_nxt;
            w2_r <= w2_nxt;
            bufPtr_r <= bufPtr_nxt;
            bufLeft_r <= bufLeft_nxt;
            msgLen_r <= msgLen_nxt;
            nChain_r <= nChain_nxt;
            rel_r <= rel_nxt;
            good_r <= good_nxt;
            endSeen_r <= endSeen_nxt;
            prio_r <= prio_nxt;
            chainIdx_r <= chainIdx_nxt;
            chainW0_r <= chainW0_nxt;
        end
    end
endmodule : rxd_ctrl_end

// [verilog/rxd_host_end.sv]
// Host end: shared memory holding the ring and buffers, plus a user port.
// Assumes the controller keeps to the single-cycle memory protocol.
`timescale 1ns/1ps
module rxd_host_end
    import rxd_pkg::*;
#(
    parameter int MEM_AW = 10
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    rxd_mem_if.host mem, // Shared memory port
    input wire logic [MEM_AW-1:0] swAddr, // Software word address
    input wire logic [15:0] swWdata, // Software write data
    input wire logic swWr, // Software write strobe
    input wire logic swRd, // Software read strobe
    output logic [15:0] swRdata // Read data, cycle after swRd
);
    logic [15:0] mem_r [2**MEM_AW];
    logic [15:0] mem_nxt [2**MEM_AW];
    logic [15:0] rdata_r, rdata_nxt, swRdata_r, swRdata_nxt;
    logic [MEM_AW-1:0] cAddr;

    assign cAddr = mem.addr[MEM_AW-1:0];
    assign mem.rdata = rdata_r;
    assign swRdata = swRdata_r;

    // Software returns entries by writing word 0 with the own bit set
    always_comb begin
        mem_nxt = mem_r;
        rdata_nxt = rdata_r;
        swRdata_nxt = swRdata_r;
        if (swWr) begin
            mem_nxt[swAddr] = swWdata;
        end
        if (mem.wr) begin
            mem_nxt[cAddr] = mem.wdata;
        end
        if (mem.rd) begin
            rdata_nxt = mem_r[cAddr];
        end
        if (swRd) begin
            swRdata_nxt = mem_r[swAddr];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
            swRdata_r <= 16'h0000;
            for (int i = 0; i < 2**MEM_AW; i++) begin
                mem_r[i] <= 16'h0000;
            end
        end else begin
            rdata_r <= rdata_nxt;
            swRdata_r <= swRdata_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule : rxd_host_end

// [verif/rxd_mem_monitor.sv]
// Checker on the shared-memory port between the two ends.
// Assumes a ring at word BASE of ENTRIES entries, BASE four-word aligned.
`timescale 1ns/1ps
module rxd_mem_monitor
    import rxd_pkg::*;
#(
    parameter int BASE = 0,
    parameter int ENTRIES = 2
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [ADDR_W-1:0] addr, // Word address
    input wire logic [DATA_W-1:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [DATA_W-1:0] rdata // Read data
);
    localparam logic [ADDR_W-1:0] LO = ADDR_W'(BASE);
    localparam logic [ADDR_W-1:0] HI = ADDR_W'(BASE + 4 * ENTRIES);
    logic inRing;
    logic w0Wr;
    logic w3Wr;
    int unsigned idx;
    logic [15:0] seenW0 [ENTRIES];
    logic rdW0_r;
    int unsigned rdIdx_r;
    assign inRing = (addr >= LO) && (addr < HI);
    assign w0Wr = wr && inRing && addr[1:0] == W0_OFS;
    assign w3Wr = wr && inRing && addr[1:0] == W3_OFS;
    assign idx = 32'((addr - LO) >> 2);
    // Last word 0 read per entry, the reference for kept bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdW0_r <= 1'b0;
            rdIdx_r <= 0;
        end else begin
            rdW0_r <= rd && inRing && addr[1:0] == W0_OFS;
            rdIdx_r <= idx;
            if (rdW0_r) begin
                seenW0[rdIdx_r] <= rdata;
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_OWN_CLEAR: assert property (w0Wr |-> !wdata[OWN_BIT])
        else $error("ownership not cleared");
    AST_RSV_ZERO: assert property (w0Wr |-> wdata[9:8] == 2'h0)
        else $error("reserved bits set");
    AST_KEEP_HOSTIOP: assert property (w0Wr |-> wdata[HOSTIOP_BIT] == seenW0[idx][HOSTIOP_BIT])
        else $error("host or processor bit changed");
    AST_KEEP_UADDR: assert property (w0Wr |-> wdata[7:0] == seenW0[idx][7:0])
        else $error("upper address changed");
    AST_W1_KEPT: assert property (!(wr && inRing && addr[1:0] == W1_OFS))
        else $error("word 1 written");
    AST_W2_KEPT: assert property (!(wr && inRing && addr[1:0] == W2_OFS))
        else $error("word 2 written");
    AST_LEN_FIRST: assert property (w0Wr |-> $past(wr) && $past(addr) == addr + 24'h3)
        else $error("release without length");
    AST_RELEASE_NEXT: assert property (w3Wr |=> w0Wr && addr == $past(addr) - 24'h3)
        else $error("length not followed by release");
endmodule : rxd_mem_monitor

// [verif/tb.sv]
// Testbench: controller and host ends joined, units streamed in, memory read back.
// Assumes a two-entry ring at word 0 and buffers at bytes 100h and 200h.
`timescale 1ns/1ps
module tb;
    import rxd_pkg::*;
    logic clk_sys, rst_n, start, jpnMode, suValid, suOdd, suEnd, suGood;
    logic suReady, unitDone, unitDropped, ringStall, swWr, swRd, rdSeen;
    logic [15:0] suData, swWdata, swRdata, curMask;
    logic [1:0] suPrio;
    logic [9:0] swAddr;
    logic [15:0] expQ[$], mskQ[$];
    logic [15:0] pairs[4];
    int n_fail = 0;
    int compares = 0;
    int w;
    integer seed = 32'hd08c0237;
    rxd_mem_if memIf();
    rxd_ctrl_end i_rxd_ctrl_end (.clk_sys, .rst_n, .mem(memIf.ctrl), .ringBase(24'h0),
        .ringCode(3'h1), .japaneseModeEnable(jpnMode), .start, .suValid, .suData, .suOdd,
        .suEnd, .suGood, .suPrio, .suReady, .unitDone, .unitDropped, .ringStall);
    rxd_host_end i_rxd_host_end (.clk_sys, .rst_n, .mem(memIf.host), .swAddr, .swWdata,
        .swWr, .swRd, .swRdata);
    rxd_mem_monitor #(.BASE(0), .ENTRIES(2)) i_rxd_mem_monitor (.clk_sys, .rst_n,
        .addr(memIf.addr), .wdata(memIf.wdata), .wr(memIf.wr), .rd(memIf.rd),
        .rdata(memIf.rdata));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo;
        n_fail++;
        $display("Error %0t: wait ran out", $time);
        results();
    endtask : tmo
    task automatic wrW(input logic [9:0] a, input logic [15:0] d);
        swRd <= 1'b0;
        swWr <= 1'b1;
        swAddr <= a;
        swWdata <= d;
        @(posedge clk_sys);
    endtask : wrW
    task automatic rdW(input logic [9:0] a, input logic [15:0] e, input logic [15:0] m);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        swWr <= 1'b0;
        swRd <= 1'b1;
        swAddr <= a;
        @(posedge clk_sys);
    endtask : rdW
    task automatic idle;
        swWr <= 1'b0;
        swRd <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : idle
    // Word 0 written last so the controller never sees a half-made entry
    task automatic setDesc(input logic [9:0] e, input logic [15:0] bufLo, input logic [15:0] len);
        wrW(10'(e * 4 + 1), bufLo);
        wrW(10'(e * 4 + 2), -len);
        wrW(10'(e * 4), 16'hc000);
        idle();
    endtask : setDesc
    task automatic sendUnit(input int n, input logic good, input logic [1:0] prio);
        for (int k = 0; k < (n + 1) / 2; k++) begin
            pairs[k] = 16'($random(seed));
            suValid <= 1'b1;
            suData <= pairs[k];
            suEnd <= (2 * k + 2 >= n);
            suOdd <= n[0];
            suGood <= good;
            suPrio <= prio;
            @(negedge clk_sys);
            for (w = 0; w < 50 && suReady !== 1'b1; w++) @(negedge clk_sys);
            if (w == 50) tmo();
            @(posedge clk_sys);
        end
        suValid <= 1'b0;
        suEnd <= 1'b0;
        @(negedge clk_sys);
        for (w = 0; w < 50 && unitDone !== 1'b1 && unitDropped !== 1'b1; w++) @(negedge clk_sys);
        if (w == 50) tmo();
        chk({15'h0, unitDone}, {15'h0, good});
        chk({15'h0, unitDropped}, {15'h0, !good});
        @(posedge clk_sys);
        idle();
    endtask : sendUnit
    always @(posedge clk_sys) rdSeen <= swRd;
    // Read results checked against the oldest note
    always @(negedge clk_sys) begin
        if (rdSeen === 1'b1 && expQ.size() > 0) begin
            curMask = mskQ.pop_front();
            chk(swRdata & curMask, expQ.pop_front());
        end
    end
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        jpnMode = 1'b0;
        {suValid, suOdd, suEnd, suGood, suPrio, suData} = '0;
        {swWr, swRd, swAddr, swWdata} = '0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        for (w = 0; w < 40 && ringStall !== 1'b1; w++) @(negedge clk_sys);
        if (w == 40) tmo();
        chk({15'h0, ringStall}, 16'h1);
        @(posedge clk_sys);
        setDesc(1, 16'h0200, 16'h8);
        setDesc(0, 16'h0100, 16'h4);
        sendUnit(6, 1'b1, 2'h3);
        rdW(0, 16'h6000, 16'hffff);
        rdW(1, 16'h0100, 16'hffff);
        rdW(2, 16'hfffc, 16'hffff);
        rdW(3, 16'hfffa, 16'hffff);
        rdW(4, 16'h5000, 16'hffff);
        rdW(7, 16'hfffa, 16'hffff);
        rdW(10'h80, pairs[0], 16'hffff);
        rdW(10'h81, pairs[1], 16'hffff);
        rdW(10'h100, pairs[2], 16'hffff);
        idle();
        $display("Chained unit done");
        setDesc(0, 16'h0100, 16'h4);
        sendUnit(2, 1'b0, 2'h0);
        rdW(0, 16'hc000, 16'hffff);
        idle();
        $display("Dropped unit done");
        jpnMode <= 1'b1;
        setDesc(1, 16'h0200, 16'h8);
        sendUnit(3, 1'b1, 2'h2);
        rdW(4, 16'h7800, 16'hffff);
        rdW(7, 16'hfffd, 16'hffff);
        rdW(10'h100, pairs[0], 16'hffff);
        rdW(10'h101, pairs[1], 16'h00ff);
        idle();
        $display("Priority unit done");
        // Partial unit cut by a restart, then a clean one-pair unit
        suValid <= 1'b1;
        suData <= 16'($random(seed));
        suEnd <= 1'b0;
        @(negedge clk_sys);
        for (w = 0; w < 50 && suReady !== 1'b1; w++) @(negedge clk_sys);
        if (w == 50) tmo();
        @(posedge clk_sys);
        suValid <= 1'b0;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        idle();
        sendUnit(2, 1'b1, 2'h1);
        rdW(0, 16'h7400, 16'hffff);
        rdW(3, 16'hfffe, 16'hffff);
        rdW(10'h80, pairs[0], 16'hffff);
        idle();
        $display("Restart unit done");
        results();
    end
endmodule : tb
